/* hdl/spec_pkg.sv */
// shared constants for the slave port error capture block
// assumes a 32-bit apb register bus, byte address = 4 * index
package spec_pkg;

    // ************************************************
    // register indices, byte address is four times these
    // ************************************************
    localparam logic [7:0] SPEC_IDX_CFG   = 8'h44;
    localparam logic [7:0] SPEC_IDX_UADDR = 8'h46;
    localparam logic [7:0] SPEC_IDX_LADDR = 8'h47;
    localparam logic [7:0] SPEC_IDX_QUAL  = 8'h48;
    localparam logic [7:0] SPEC_IDX_MISC  = 8'h49;
    localparam logic [7:0] SPEC_IDX_IRQ   = 8'h40;

    // ************************************************
    // configuration fields and reset
    // ************************************************
    localparam int SPEC_CFG_HOLD   = 0;
    localparam int SPEC_CFG_POST   = 28;
    localparam int SPEC_CFG_LOG    = 30;
    localparam int SPEC_CFG_NOCHK  = 31;
    localparam logic [31:0] SPEC_CFG_RST  = 32'h3000_0000;
    localparam logic [31:0] SPEC_CFG_MASK = 32'hd000_0001;
    localparam logic [31:0] SPEC_CFG_ONE  = 32'h2000_0000;

    // ************************************************
    // qualifier fields
    // ************************************************
    localparam int SPEC_Q_VALID = 0;
    localparam int SPEC_Q_LOCK  = 1;
    localparam int SPEC_Q_MID   = 4;
    localparam int SPEC_Q_WIDTH = 6;
    localparam int SPEC_Q_TYPE  = 8;
    localparam int SPEC_Q_RNW   = 11;
    localparam int SPEC_Q_SIZE  = 12;
    localparam int SPEC_Q_BE    = 16;

    // ************************************************
    // misc flags and interrupt status bits
    // ************************************************
    localparam int SPEC_M_POST  = 0;
    localparam int SPEC_M_ILL   = 1;
    localparam int SPEC_M_ADDR  = 2;
    localparam int SPEC_M_QUEUE = 18;
    localparam int SPEC_NQ_BITS = 14;
    localparam int SPEC_IRQ_CMD = 11;
    localparam int SPEC_IRQ_Q   = 15;

    // ************************************************
    // command size codes
    // ************************************************
    localparam logic [3:0] SPEC_SZ_SINGLE = 4'h0;
    localparam logic [3:0] SPEC_SZ_LINE4  = 4'h1;
    localparam logic [3:0] SPEC_SZ_LINE8  = 4'h2;
    localparam logic [3:0] SPEC_SZ_LINE16 = 4'h3;
    localparam logic [3:0] SPEC_SZ_BST32  = 4'ha;
    localparam logic [3:0] SPEC_SZ_BST64  = 4'hb;
    localparam logic [3:0] SPEC_SZ_BST128 = 4'hc;

    typedef enum logic [1:0] {
        SPEC_APB_IDLE,
        SPEC_APB_WAIT,
        SPEC_APB_DONE
    } spec_apb_e;

endpackage

/* hdl/spec_cmd_check.sv */
// command classifier for the slave port error capture block
// assumes command fields come from logic on the same clock
`timescale 1ns/100ps
`default_nettype none

module spec_cmd_check
    import spec_pkg::*;
(
    // command under test
    input  wire logic [3:0] size,
    input  wire logic       addr_miss,
    // configuration
    input  wire logic       posting_on,
    input  wire logic       check_off,
    input  wire logic       log_miss,
    // classification
    output logic            post_fault,
    output logic            ill_fault,
    output logic            addr_fault,
    output logic            failed
);

    // ************************************************
    // supported size codes
    // ************************************************
    function automatic logic size_ok(input logic [3:0] s);
        case (s)
            SPEC_SZ_SINGLE, SPEC_SZ_LINE4, SPEC_SZ_LINE8,
            SPEC_SZ_LINE16, SPEC_SZ_BST32, SPEC_SZ_BST64,
            SPEC_SZ_BST128: size_ok = 1'b1;
            default:        size_ok = 1'b0;
        endcase
    endfunction

    // size check only runs while not disabled
    always_comb begin
        ill_fault  = !check_off && !size_ok(size);
        post_fault = !check_off && !posting_on
                     && size_ok(size)
                     && (size != SPEC_SZ_SINGLE);
        addr_fault = log_miss && addr_miss;
        // mismatches capture even when not logged as a flag
        failed     = ill_fault || post_fault || addr_miss;
    end

endmodule

`default_nettype wire

/* hdl/spec_top.sv */
// error capture registers for one slave port, apb slave
// assumes command strobes and queue events on the same clock
// paddr above the word index is not decoded, so indices alias
// every apb access takes one wait state; there are no byte strobes
`timescale 1ns/100ps
`default_nettype none

module spec_top
    import spec_pkg::*;
#(
    parameter int NQ = SPEC_NQ_BITS
)(
    // clock and reset
    input  wire logic          clk,
    input  wire logic          rst_n,
    // apb slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    // command observed on the local bus
    input  wire logic          cmd_strobe,
    input  wire logic [35:0]   cmd_addr,
    input  wire logic          cmd_addr_miss,
    input  wire logic [3:0]    cmd_size,
    input  wire logic          read_not_write,
    input  wire logic [15:0]   byte_lane_enables,
    input  wire logic [1:0]    cmd_master_id,
    input  wire logic [1:0]    requester_width,
    input  wire logic [2:0]    cmd_type,
    input  wire logic          master_lock_fault,
    // sniffer match and queue events
    input  wire logic          sniff_hit,
    input  wire logic [NQ-1:0] queue_event,
    // interrupt status levels
    output logic               irq_cmd_fault,
    output logic               irq_queue_fault
);

    // ************************************************
    // storage
    // ************************************************
    logic [31:0] cfg_r;
    logic [3:0]  upper_address_nibble_r;
    logic [31:0] low_address_word_r;
    logic [31:0] qual_r;
    logic [31:0] misc_r;
    logic [31:0] misc_nxt;
    spec_apb_e   apb_r;
    logic [31:0] rd_mux;
    logic        rd_hit;
    logic [7:0]  idx;

    // ************************************************
    // classification
    // ************************************************
    logic post_fault;
    logic ill_fault;
    logic addr_fault;
    logic failed;

    // mismatches capture unless hold blocks them; config bit 30 only gates the flag
    spec_cmd_check u_check (
        .size       (cmd_size),
        .addr_miss  (cmd_addr_miss),
        .posting_on (cfg_r[SPEC_CFG_POST]),
        .check_off  (cfg_r[SPEC_CFG_NOCHK]),
        .log_miss   (cfg_r[SPEC_CFG_LOG]),
        .post_fault (post_fault),
        .ill_fault  (ill_fault),
        .addr_fault (addr_fault),
        .failed     (failed)
    );

    // ************************************************
    // bus decode
    // ************************************************
    // register index from the word address
    assign idx = paddr[9:2];

    logic wr_commit;
    logic wr_cfg;
    logic wr_qual;
    logic wr_misc;

    // writes land only on the completing edge
    assign wr_commit = psel && penable && pwrite
                       && (apb_r == SPEC_APB_DONE);
    assign wr_cfg  = wr_commit && (idx == SPEC_IDX_CFG);
    assign wr_qual = wr_commit && (idx == SPEC_IDX_QUAL);
    assign wr_misc = wr_commit && (idx == SPEC_IDX_MISC);

    // ************************************************
    // capture decision
    // ************************************************
    logic event_any;
    logic cap_ok;
    logic capture;

    // sniffer matches load like failures
    assign event_any = (cmd_strobe && failed) || sniff_hit;
    // a capture in the clearing cycle is kept rather than lost
    // hold keeps the first one; a clear frees the slot
    assign cap_ok  = !cfg_r[SPEC_CFG_HOLD]
                     || !qual_r[SPEC_Q_VALID]
                     || wr_qual;
    assign capture = event_any && cap_ok;

    // ************************************************
    // configuration register
    // ************************************************
    // only hold, posting, logging and check-off bits are writable
    // reserved bit 29 is forced to one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r <= SPEC_CFG_RST;
        end else if (wr_cfg) begin
            cfg_r <= (pwdata & SPEC_CFG_MASK) | SPEC_CFG_ONE;
        end
    end

    // ************************************************
    // address capture
    // ************************************************
    // capture beats the clearing write in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_address_word_r <= 32'h0000_0000;
        end else if (capture) begin
            low_address_word_r <= cmd_addr[31:0];
        end else if (wr_qual) begin
            low_address_word_r <= 32'h0000_0000;
        end
    end

    // upper nibble follows the same clear path
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            upper_address_nibble_r <= 4'h0;
        end else if (capture) begin
            upper_address_nibble_r <= cmd_addr[35:32];
        end else if (wr_qual) begin
            upper_address_nibble_r <= 4'h0;
        end
    end

    // ************************************************
    // qualifier capture
    // ************************************************
    // valid is set in the same edge as the data
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            qual_r <= 32'h0000_0000;
        end else if (capture) begin
            // reserved bits 2-3 stay zero from this clear
            qual_r <= 32'h0000_0000;
            qual_r[SPEC_Q_VALID]    <= 1'b1;
            qual_r[SPEC_Q_LOCK]     <= master_lock_fault;
            qual_r[SPEC_Q_MID +: 2] <= cmd_master_id;
            qual_r[SPEC_Q_WIDTH +: 2] <= requester_width;
            qual_r[SPEC_Q_TYPE +: 3]  <= cmd_type;
            qual_r[SPEC_Q_RNW]      <= read_not_write;
            qual_r[SPEC_Q_SIZE +: 4] <= cmd_size;
            qual_r[SPEC_Q_BE +: 16] <= byte_lane_enables;
        end else if (wr_qual) begin
            // data value is ignored: any write clears
            qual_r <= 32'h0000_0000;
        end
    end

    // ************************************************
    // sticky miscellaneous flags
    // ************************************************
    logic [31:0]   misc_set;
    logic [31:0]   misc_clr;
    logic [NQ-1:0] queue_set;

    // queues report as over/under pairs, overflow in the even slot:
    // read data, write data, slave read, slave write, master read,
    // master write, input command, from the low end upward
    for (genvar q = 0; q < NQ / 2; q++) begin : g_queue_pair
        assign queue_set[2 * q]     = queue_event[2 * q];
        assign queue_set[2 * q + 1] = queue_event[2 * q + 1];
    end

    // event bits per position; reserved bits 3-17 never set
    always_comb begin
        misc_set = 32'h0000_0000;
        misc_set[SPEC_M_POST] = cmd_strobe && post_fault;
        misc_set[SPEC_M_ILL]  = cmd_strobe && ill_fault;
        misc_set[SPEC_M_ADDR] = cmd_strobe && addr_fault;
        misc_set[SPEC_M_QUEUE +: NQ] = queue_set;
    end

    // write one clears, zero leaves bit alone
    assign misc_clr = wr_misc ? pwdata : 32'h0000_0000;

    // a fresh event wins over the clearing write
    always_comb begin
        misc_nxt = (misc_r & ~misc_clr) | misc_set;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            misc_r <= 32'h0000_0000;
        end else begin
            misc_r <= misc_nxt;
        end
    end

    // ************************************************
    // interrupt status levels
    // ************************************************
    // command level from the next flag value so no extra lag
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_cmd_fault <= 1'b0;
        end else begin
            irq_cmd_fault <= |misc_nxt[SPEC_M_ADDR:SPEC_M_POST];
        end
    end

    // queue level, same timing as the command level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_queue_fault <= 1'b0;
        end else begin
            irq_queue_fault <= |misc_nxt[SPEC_M_QUEUE +: NQ];
        end
    end

    // ************************************************
    // read decode
    // ************************************************
    // interrupt view shows the two status bits only
    // unmapped indices answer with an error and zero data
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        case (idx)
            SPEC_IDX_CFG:   rd_mux = cfg_r;
            SPEC_IDX_UADDR: rd_mux = {28'h0000000,
                                      upper_address_nibble_r};
            SPEC_IDX_LADDR: rd_mux = low_address_word_r;
            SPEC_IDX_QUAL:  rd_mux = qual_r;
            SPEC_IDX_MISC:  rd_mux = misc_r;
            SPEC_IDX_IRQ: begin
                rd_mux[SPEC_IRQ_CMD] = irq_cmd_fault;
                rd_mux[SPEC_IRQ_Q]   = irq_queue_fault;
            end
            default:        rd_hit = 1'b0;
        endcase
    end

    // ************************************************
    // apb handshake
    // ************************************************
    // one wait state: answer registered so outputs are flops
    // the enum's wait state is never entered; no access stalls
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            apb_r <= SPEC_APB_IDLE;
        end else begin
            case (apb_r)
                SPEC_APB_IDLE: begin
                    if (psel && penable) begin
                        apb_r <= SPEC_APB_DONE;
                    end
                end
                SPEC_APB_DONE: apb_r <= SPEC_APB_IDLE;
                default:       apb_r <= SPEC_APB_IDLE;
            endcase
        end
    end

    // an access phase seen while idle is taken at this edge
    logic apb_take;
    assign apb_take = (apb_r == SPEC_APB_IDLE) && psel && penable;

    // ready is a one-cycle pulse after each taken access
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
        end else begin
            pready <= apb_take;
        end
    end

    // error stands only beside ready, for an unmapped index
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pslverr <= 1'b0;
        end else if (apb_take) begin
            pslverr <= !rd_hit;
        end else begin
            pslverr <= 1'b0;
        end
    end

    // read data is zero outside the answer, so no stale value leaks
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (apb_take && !pwrite) begin
            prdata <= rd_mux;
        end else begin
            prdata <= 32'h0000_0000;
        end
    end

endmodule

`default_nettype wire

/* test/spec_top_sva.sv */
// checker for the error capture block, watches the top ports only
// assumes one clock domain and the async active-low reset
`timescale 1ns/100ps
`default_nettype none

module spec_top_sva
    import spec_pkg::*;
#(
    parameter int NQ = SPEC_NQ_BITS
)(
    // clock and reset
    input wire logic          clk,
    input wire logic          rst_n,
    // apb slave
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [11:0]   paddr,
    input wire logic [31:0]   pwdata,
    input wire logic [31:0]   prdata,
    input wire logic          pready,
    input wire logic          pslverr,
    // command side
    input wire logic          cmd_strobe,
    input wire logic          cmd_addr_miss,
    input wire logic [3:0]    cmd_size,
    input wire logic [NQ-1:0] queue_event,
    // interrupt levels
    input wire logic          irq_cmd_fault,
    input wire logic          irq_queue_fault
);
    logic [31:0] cfg_r;
    logic        wr_hit;
    logic        misc_wr;
    logic        illegal;
    logic        multi;

    // decode of writes and size classes
    assign wr_hit  = psel && penable && pready && pwrite;
    assign misc_wr = wr_hit && paddr[9:2] == SPEC_IDX_MISC;
    assign multi   = cmd_size inside {[4'h1:4'h3], [4'ha:4'hc]};
    assign illegal = !(multi || cmd_size == SPEC_SZ_SINGLE);

    // shadow of the config word, needed because the gates are not on a port
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r <= SPEC_CFG_RST;
        end else if (wr_hit && paddr[9:2] == SPEC_IDX_CFG) begin
            cfg_r <= (pwdata & SPEC_CFG_MASK) | SPEC_CFG_ONE;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    apb_answer_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
        else $error("apb answer not a single pulse");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    ill_flag_a: assert property (cmd_strobe && illegal && !cfg_r[31] |=> irq_cmd_fault)
        else $error("illegal size did not raise command fault");
    post_flag_a: assert property (cmd_strobe && multi && !cfg_r[28] && !cfg_r[31] |=> irq_cmd_fault)
        else $error("multi transfer without posting not flagged");
    miss_flag_a: assert property (cmd_strobe && cmd_addr_miss && cfg_r[30] |=> irq_cmd_fault)
        else $error("logged mismatch not flagged");
    queue_flag_a: assert property (|queue_event |=> irq_queue_fault)
        else $error("queue event not flagged");
    queue_sticky_a: assert property (irq_queue_fault && !misc_wr |=> irq_queue_fault)
        else $error("queue flag dropped without a write");
    cmd_sticky_a: assert property (irq_cmd_fault && !misc_wr |=> irq_cmd_fault)
        else $error("command flag dropped without a write");
    cmd_quiet_a: assert property (!irq_cmd_fault && !cmd_strobe |=> !irq_cmd_fault)
        else $error("command fault raised with no command");

    illegal_c: cover property (cmd_strobe && illegal);
    queue_c: cover property (|queue_event);
    unmapped_c: cover property (pready && pslverr);
endmodule

bind spec_top spec_top_sva #(.NQ(NQ)) u_spec_top_sva (.clk, .rst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cmd_strobe, .cmd_addr_miss,
    .cmd_size, .queue_event, .irq_cmd_fault, .irq_queue_fault);

`default_nettype wire

/* test/spec_master_model.sv */
// model of a local bus master feeding the slave port command observer
// assumes the caller enters issue just after a rising clock edge
`timescale 1ns/100ps
`default_nettype none

module spec_master_model (
    // clock
    input wire logic    clk,
    // command toward the slave port
    output logic        cmd_strobe,
    output logic [35:0] cmd_addr,
    output logic        cmd_addr_miss,
    output logic [3:0]  cmd_size,
    output logic        read_not_write,
    output logic [15:0] byte_lane_enables,
    output logic [1:0]  cmd_master_id,
    output logic [1:0]  requester_width,
    output logic [2:0]  cmd_type,
    output logic        master_lock_fault,
    output logic        sniff_hit
);
    // idle at time zero
    initial begin
        {cmd_strobe, sniff_hit, cmd_addr, cmd_addr_miss, cmd_size} = '0;
        {read_not_write, byte_lane_enables, cmd_master_id} = '0;
        {requester_width, cmd_type, master_lock_fault} = '0;
    end

    // one command beat; other qualifiers derive from the address so the
    // bench can predict them; address, size, direction, miss and lock are scrambled once the beat is over
    task automatic issue(input logic [35:0] a, input logic [3:0] sz, input logic miss,
                         input logic lock, input logic sn);
        cmd_strobe        <= !sn;
        sniff_hit         <= sn;
        cmd_addr          <= a;
        cmd_addr_miss     <= miss;
        cmd_size          <= sz;
        read_not_write    <= a[8];
        byte_lane_enables <= a[31:16];
        cmd_master_id     <= a[5:4];
        requester_width   <= a[7:6];
        cmd_type          <= a[14:12];
        master_lock_fault <= lock;
        @(posedge clk);
        {cmd_strobe, sniff_hit} <= 2'b00;
        {cmd_addr, cmd_size, read_not_write} <= ~{a, sz, a[8]};
        {cmd_addr_miss, master_lock_fault} <= ~{miss, lock};
        @(posedge clk);
    endtask
endmodule

`default_nettype wire

/* test/test_spec_top.sv */
// self-checking bench for the error capture registers over apb
// assumes the master model and checker files are compiled before it
`timescale 1ns/100ps
`default_nettype none

module test_spec_top;
    import spec_pkg::*;
    localparam logic [35:0] A1 = 36'h9_89ab_cd75;
    localparam logic [35:0] A2 = 36'h3_1357_9a20;
    localparam logic [35:0] A3 = 36'h5_0246_8c4b;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic        pready, pslverr, rd_err, cmd_strobe, cmd_addr_miss, read_not_write;
    logic        master_lock_fault, sniff_hit, irq_cmd_fault, irq_queue_fault;
    logic [35:0] cmd_addr;
    logic [3:0]  cmd_size;
    logic [15:0] byte_lane_enables;
    logic [1:0]  cmd_master_id, requester_width;
    logic [2:0]  cmd_type;
    logic [13:0] queue_event = '0;
    int          errors = 0, num_checks = 0;

    always #5 clk = ~clk;

    spec_top u_spec_top (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .cmd_strobe, .cmd_addr, .cmd_addr_miss, .cmd_size,
        .read_not_write, .byte_lane_enables, .cmd_master_id, .requester_width, .cmd_type,
        .master_lock_fault, .sniff_hit, .queue_event, .irq_cmd_fault, .irq_queue_fault);
    spec_master_model u_spec_master_model (.clk, .cmd_strobe, .cmd_addr, .cmd_addr_miss,
        .cmd_size, .read_not_write, .byte_lane_enables, .cmd_master_id, .requester_width,
        .cmd_type, .master_lock_fault, .sniff_hit);

    // apb transfer; waits for pready, the watchdog bounds a hang
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic rchk(input logic [7:0] idx, input logic [31:0] exp, input string m);
        apb(1'b0, idx, 32'h0);
        chk(rd, exp, m);
    endtask

    // qualifier word the slave port should hold for one captured command
    function automatic logic [31:0] qv(input logic [35:0] a, input logic [3:0] sz,
                                       input logic lock);
        return {a[31:16], sz, a[8], a[14:12], a[7:6], a[5:4], 2'b00, lock, 1'b1};
    endfunction

    task report_and_stop;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // watchdog, far beyond the roughly five hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        report_and_stop;
    end

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rchk(SPEC_IDX_LADDR, 32'h0, "laddr reset");
        rchk(SPEC_IDX_QUAL, 32'h0, "qual reset");
        rchk(SPEC_IDX_MISC, 32'h0, "misc reset");
        rchk(SPEC_IDX_CFG, SPEC_CFG_RST, "cfg reset");
        apb(1'b0, 8'h4f, 32'h0);
        chk({31'h0, rd_err}, 32'h1, "unmapped error");
        $display("test reset done");
        u_spec_master_model.issue(A1, 4'h5, 1'b0, 1'b1, 1'b0);
        rchk(SPEC_IDX_LADDR, A1[31:0], "low address");
        rchk(SPEC_IDX_UADDR, {28'h0, A1[35:32]}, "upper address");
        rchk(SPEC_IDX_QUAL, qv(A1, 4'h5, 1'b1), "qualifiers");
        rchk(SPEC_IDX_IRQ, 32'h0000_0800, "irq status");
        u_spec_master_model.issue(A2, 4'h0, 1'b1, 1'b0, 1'b0);
        rchk(SPEC_IDX_LADDR, A2[31:0], "mismatch overwrite");
        rchk(SPEC_IDX_MISC, 32'h2, "mismatch not logged");
        u_spec_master_model.issue(A3, 4'h1, 1'b0, 1'b0, 1'b1);
        rchk(SPEC_IDX_QUAL, qv(A3, 4'h1, 1'b0), "sniff capture");
        apb(1'b1, SPEC_IDX_QUAL, 32'h1234_0000);
        rchk(SPEC_IDX_QUAL, 32'h0, "qual cleared");
        rchk(SPEC_IDX_LADDR, 32'h0, "laddr cleared");
        apb(1'b1, SPEC_IDX_MISC, 32'h0);
        rchk(SPEC_IDX_MISC, 32'h2, "zero write keeps");
        apb(1'b1, SPEC_IDX_MISC, 32'h2);
        rchk(SPEC_IDX_MISC, 32'h0, "one write clears");
        rchk(SPEC_IDX_IRQ, 32'h0, "irq idle");
        $display("test capture done");
        apb(1'b1, SPEC_IDX_CFG, 32'h3000_0001);
        u_spec_master_model.issue(A1, 4'h5, 1'b0, 1'b0, 1'b0);
        u_spec_master_model.issue(A2, 4'h0, 1'b1, 1'b0, 1'b0);
        rchk(SPEC_IDX_LADDR, A1[31:0], "hold keeps first");
        apb(1'b1, SPEC_IDX_CFG, 32'h6000_0000);
        apb(1'b1, SPEC_IDX_MISC, 32'hffff_ffff);
        u_spec_master_model.issue(A2, 4'hb, 1'b0, 1'b0, 1'b0);
        u_spec_master_model.issue(A1, 4'h0, 1'b1, 1'b0, 1'b0);
        rchk(SPEC_IDX_MISC, 32'h5, "posting and mismatch");
        apb(1'b1, SPEC_IDX_CFG, 32'hb000_0000);
        apb(1'b1, SPEC_IDX_QUAL, 32'h0);
        apb(1'b1, SPEC_IDX_MISC, 32'hffff_ffff);
        u_spec_master_model.issue(A1, 4'h5, 1'b0, 1'b0, 1'b0);
        rchk(SPEC_IDX_MISC, 32'h0, "check off flags");
        rchk(SPEC_IDX_QUAL, 32'h0, "check off capture");
        $display("test config done");
        apb(1'b1, SPEC_IDX_CFG, SPEC_CFG_RST);
        for (int i = 0; i < 16; i++) begin
            u_spec_master_model.issue(A3, 4'(i), 1'b0, 1'b0, 1'b0);
            rchk(SPEC_IDX_MISC, {30'h0, !(i inside {[0:3], [10:12]}), 1'b0}, "size");
            apb(1'b1, SPEC_IDX_MISC, 32'h2);
        end
        for (int k = 0; k < 14; k++) begin
            queue_event <= 14'(1 << k);
            @(posedge clk);
            queue_event <= '0;
            rchk(SPEC_IDX_MISC, 32'(1) << (18 + k), "queue flag");
            rchk(SPEC_IDX_IRQ, 32'h0000_8000, "queue irq");
            apb(1'b1, SPEC_IDX_MISC, 32'(1) << (18 + k));
        end
        $display("test tables done");
        report_and_stop;
    end
endmodule

`default_nettype wire
